// >>> verilog/data_mover_pkg.sv
// Package: constants and types for the dual priority data mover
package data_mover_pkg;
  localparam int NEVT  = 32;
  localparam int NXFER = 8;
  localparam int NWORD = 5;
  localparam logic [11:0] OFF_POL  = 12'h008;
  localparam logic [11:0] OFF_EN   = 12'h00C;
  localparam logic [11:0] OFF_DIS  = 12'h010;
  localparam logic [11:0] OFF_HIP  = 12'h014;
  localparam logic [11:0] OFF_LOP  = 12'h018;
  localparam logic [11:0] OFF_FLAG = 12'h01C;
  localparam logic [11:0] OFF_TRIG = 12'h024;
  localparam logic [11:0] OFF_IST  = 12'h028;
  localparam logic [11:0] OFF_ICLR = 12'h02C;
  localparam logic [11:0] OFF_IEN  = 12'h030;
  localparam logic [11:0] OFF_LVL  = 12'h034;
  localparam logic [11:0] OFF_STAT = 12'h038;
  localparam logic [1:0]  RAM_HI   = 2'h1;
  localparam logic [1:0]  RAM_LO   = 2'h2;
  localparam logic [31:0] EVT_VALID = 32'hFDFF_FFFF;
  localparam logic [31:0] SW_POS    = 32'hC186_0C03;
  localparam int EE_KIND = 0;
  localparam int EE_PTR  = 1;
  localparam int EE_IRQ  = 4;
  localparam int EE_DONE = 9;
  localparam int RGN_HI  = 31;
  localparam int RGN_LO  = 28;

  typedef enum logic [1:0] {MV_IDLE = 2'b00, MV_RD = 2'b01, MV_WR = 2'b10} mover_e;
  typedef enum logic [1:0] {PT_IDLE = 2'b00, PT_BUSY = 2'b01, PT_EXT = 2'b10} port_e;
  typedef enum logic [1:0] {OWN_HI = 2'b00, OWN_LO = 2'b01} owner_e;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [7:0]  cnt2;
    logic [7:0]  cnt1;
    logic [7:0]  cnt0;
    logic [15:0] idx2;
    logic [15:0] idx1;
    logic [15:0] circ;
  } xfer_s;

  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_cmd_s;

  // Software trigger bits onto their event positions
  function automatic logic [31:0] sw_events(input logic [31:0] t);
    logic [31:0] r;
    r = '0;
    r[0]  = t[0];
    r[1]  = t[16];
    r[10] = t[1];
    r[11] = t[17];
    r[17] = t[2];
    r[18] = t[18];
    r[23] = t[3];
    r[24] = t[19];
    r[30] = t[20];
    r[31] = t[21];
    return r;
  endfunction

  // Lowest set bit wins
  function automatic logic [4:0] first_set(input logic [31:0] v);
    logic [4:0] r;
    r = '0;
    for (int i = NEVT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction
endpackage

// >>> verilog/dual_priority_data_mover.sv
// Event driven two-group data mover with APB registers
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/100ps
module dual_priority_data_mover
  import data_mover_pkg::*;
(
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [15:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Event pins
  input  wire logic [31:0]              evt_pins,
  // Crossbar slave port
  output data_mover_pkg::mem_cmd_s      mem_cmd,
  output logic                          mem_valid,
  input  wire logic                     mem_ready,
  input  wire logic [31:0]              mem_rdata,
  // Other crossbar masters
  input  wire logic                     ext_req,
  output logic                          ext_gnt,
  // Interrupt
  output logic                          irq
);
  import data_mover_pkg::*;
  logic [31:0]  sync1_r, sync2_r, lvl_r, prev_r, flag_r, pol_r, en_r, grp_r;
  logic [31:0]  trig_r, ist_r, ien_r, cap, flag_clr, ist_set;
  logic [31:0]  ev_ram [2][NEVT];
  logic [31:0]  tw_ram [2][NXFER][NWORD];
  logic         pready_r, pslverr_r, irq_r, mem_valid_r, ext_gnt_r, wr_en, rd_ok;
  logic [31:0]  prdata_r, rdata_r, rd_val;
  mem_cmd_s     mem_cmd_r;
  port_e        pt_r;
  owner_e       own_r;
  logic [1:0]   done_r, take, want, active, conf, fin;
  logic [4:0]   pick [2];
  logic [31:0]  ee_now [2];
  logic [31:0]  src_a [2];
  logic [31:0]  dst_a [2];
  logic [31:0]  irq_hit [2];
  mem_cmd_s     cmd [2];
  logic [1:0]   mv_st [2];
  logic         ram_g;
  logic         ram_sel;
  function automatic logic hit(input logic [15:0] a, input logic [11:0] off);
    return a[15:12] == 4'h0 && a[11:0] == off;
  endfunction
  // Offset with three dimensions and optional circular wrap
  function automatic logic [31:0] gen_addr(input logic [31:0] base, input xfer_s x,
                                           input logic [7:0] c0, input logic [7:0] c1,
                                           input logic [7:0] c2);
    logic [31:0] off;
    off = {22'h0, c0, 2'h0} + 32'(c1) * 32'(x.idx1) + 32'(c2) * 32'(x.idx2);
    if (x.circ != 16'h0) begin
      off = off % 32'(x.circ);
    end
    return base + off;
  endfunction
  // Event inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= evt_pins;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_r  <= '0;
      prev_r <= '0;
    end else begin
      lvl_r  <= (sync2_r & ~SW_POS & EVT_VALID) | sw_events(trig_r);
      prev_r <= lvl_r;
    end
  end
  assign cap = (pol_r & prev_r & ~lvl_r) | (~pol_r & ~prev_r & lvl_r);
  always_comb begin
    flag_clr = (wr_en && hit(paddr, OFF_FLAG)) ? pwdata : '0;
    ist_set  = '0;
    for (int g = 0; g < 2; g++) begin
      if (take[g]) begin
        flag_clr[pick[g]] = 1'b1;
      end
      ist_set = ist_set | irq_hit[g];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= '0;
    end else begin
      flag_r <= (flag_r & ~flag_clr) | (cap & EVT_VALID);
    end
  end
  // APB slave, one wait state
  assign wr_en   = psel && penable && pready_r && pwrite;
  assign ram_g   = paddr[13:12] == RAM_LO;
  assign ram_sel = paddr[15:14] == 2'h0 && (paddr[13:12] == RAM_HI || paddr[13:12] == RAM_LO);
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = '0;
    if (ram_sel && !paddr[8] && !paddr[7]) begin
      rd_val = ev_ram[ram_g][paddr[6:2]];
    end else if (ram_sel && paddr[8] && paddr[4:2] < 3'(NWORD)) begin
      rd_val = tw_ram[ram_g][paddr[7:5]][paddr[4:2]];
    end else if (hit(paddr, OFF_POL)) begin
      rd_val = pol_r;
    end else if (hit(paddr, OFF_EN)) begin
      rd_val = en_r;
    end else if (hit(paddr, OFF_HIP)) begin
      rd_val = grp_r;
    end else if (hit(paddr, OFF_FLAG)) begin
      rd_val = flag_r;
    end else if (hit(paddr, OFF_TRIG)) begin
      rd_val = trig_r;
    end else if (hit(paddr, OFF_IST)) begin
      rd_val = ist_r;
    end else if (hit(paddr, OFF_IEN)) begin
      rd_val = ien_r;
    end else if (hit(paddr, OFF_LVL)) begin
      rd_val = lvl_r;
    end else if (hit(paddr, OFF_STAT)) begin
      rd_val = {26'h0, pt_r, mv_st[1], mv_st[0]};
    end else if (!(hit(paddr, OFF_DIS) || hit(paddr, OFF_LOP) || hit(paddr, OFF_ICLR))) begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel && penable && !pready_r;
      prdata_r  <= pwrite ? '0 : rd_val;
      pslverr_r <= psel && penable && !pready_r && !rd_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_r  <= '0;
      en_r   <= '0;
      grp_r  <= '0;
      trig_r <= '0;
      ien_r  <= '0;
    end else if (wr_en) begin
      if (hit(paddr, OFF_POL)) pol_r <= pwdata;
      if (hit(paddr, OFF_EN)) en_r <= en_r | pwdata;
      if (hit(paddr, OFF_DIS)) en_r <= en_r & ~pwdata;
      if (hit(paddr, OFF_HIP)) grp_r <= grp_r | pwdata;
      if (hit(paddr, OFF_LOP)) grp_r <= grp_r & ~pwdata;
      if (hit(paddr, OFF_TRIG)) trig_r <= pwdata;
      if (hit(paddr, OFF_IEN)) ien_r <= pwdata;
    end
  end
  // Parameter RAM of both groups
  always_ff @(posedge pclk) begin
    if (wr_en && ram_sel && !paddr[8] && !paddr[7]) begin
      ev_ram[ram_g][paddr[6:2]] <= pwdata;
    end
    if (wr_en && ram_sel && paddr[8] && paddr[4:2] < 3'(NWORD)) begin
      tw_ram[ram_g][paddr[7:5]][paddr[4:2]] <= pwdata;
    end
  end
  // Interrupt status, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= '0;
      irq_r <= 1'b0;
    end else begin
      ist_r <= (ist_r & ~((wr_en && hit(paddr, OFF_ICLR)) ? pwdata : '0)) | ist_set;
      irq_r <= |(ist_r & ien_r);
    end
  end
  // Movers, one per group
  assign conf[0] = 1'b0;
  assign conf[1] = active[0] && (src_a[1][RGN_HI:RGN_LO] == src_a[0][RGN_HI:RGN_LO] ||
                                 dst_a[1][RGN_HI:RGN_LO] == dst_a[0][RGN_HI:RGN_LO]);
  for (genvar g = 0; g < 2; g++) begin : g_mv
    mover_e      st_r;
    xfer_s       xe_r;
    logic [31:0] ee_r, data_r, pend;
    logic [7:0]  c0_r, c1_r, c2_r;
    logic        l0, l1, l2;
    assign pend       = flag_r & en_r & (g == 0 ? grp_r : ~grp_r);
    assign pick[g]    = first_set(pend);
    assign ee_now[g]  = ev_ram[g][pick[g]];
    assign take[g]    = st_r == MV_IDLE && |pend;
    assign active[g]  = st_r != MV_IDLE;
    assign mv_st[g]   = st_r;
    assign src_a[g]   = gen_addr(xe_r.src, xe_r, c0_r, c1_r, c2_r);
    assign dst_a[g]   = gen_addr(xe_r.dst, xe_r, c0_r, c1_r, c2_r);
    assign want[g]    = active[g] && !done_r[g] && !conf[g];
    assign cmd[g]     = {st_r == MV_WR, st_r == MV_WR ? dst_a[g] : src_a[g], data_r};
    assign l0 = ({1'b0, c0_r} + 9'h001) >= {1'b0, xe_r.cnt0};
    assign l1 = ({1'b0, c1_r} + 9'h001) >= {1'b0, xe_r.cnt1};
    assign l2 = ({1'b0, c2_r} + 9'h001) >= {1'b0, xe_r.cnt2};
    assign fin[g] = st_r == MV_WR && done_r[g] && l0 && l1 && l2;
    always_comb begin
      irq_hit[g] = '0;
      if (take[g] && ee_now[g][EE_KIND]) begin
        irq_hit[g][ee_now[g][EE_IRQ +: 5]] = 1'b1;
      end else if (fin[g] && ee_r[EE_DONE]) begin
        irq_hit[g][ee_r[EE_IRQ +: 5]] = 1'b1;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_r   <= MV_IDLE;
        xe_r   <= '0;
        ee_r   <= '0;
        data_r <= '0;
        c0_r   <= '0;
        c1_r   <= '0;
        c2_r   <= '0;
      end else begin
        unique case (st_r)
          MV_IDLE: begin
            if (take[g] && !ee_now[g][EE_KIND]) begin
              ee_r <= ee_now[g];
              xe_r <= {tw_ram[g][ee_now[g][EE_PTR +: 3]][0], tw_ram[g][ee_now[g][EE_PTR +: 3]][1],
                       tw_ram[g][ee_now[g][EE_PTR +: 3]][2][23:0], tw_ram[g][ee_now[g][EE_PTR +: 3]][3],
                       tw_ram[g][ee_now[g][EE_PTR +: 3]][4][15:0]};
              c0_r <= '0;
              c1_r <= '0;
              c2_r <= '0;
              st_r <= MV_RD;
            end
          end
          MV_RD: begin
            if (done_r[g]) begin
              data_r <= rdata_r;
              st_r   <= MV_WR;
            end
          end
          MV_WR: begin
            if (done_r[g]) begin
              st_r <= MV_RD;
              c0_r <= l0 ? '0 : c0_r + 8'h01;
              if (l0) begin
                c1_r <= l1 ? '0 : c1_r + 8'h01;
                if (l1) begin
                  c2_r <= l2 ? '0 : c2_r + 8'h01;
                  if (l2) st_r <= MV_IDLE;
                end
              end
            end
          end
          default: st_r <= MV_IDLE;
        endcase
      end
    end
  end
  // Crossbar slave port arbitration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pt_r        <= PT_IDLE;
      own_r       <= OWN_HI;
      mem_cmd_r   <= '0;
      mem_valid_r <= 1'b0;
      ext_gnt_r   <= 1'b0;
      done_r      <= '0;
      rdata_r     <= '0;
    end else begin
      done_r <= '0;
      unique case (pt_r)
        PT_IDLE: begin
          if (want[0]) begin
            mem_cmd_r   <= cmd[0];
            own_r       <= OWN_HI;
            mem_valid_r <= 1'b1;
            pt_r        <= PT_BUSY;
          end else if (want[1]) begin
            mem_cmd_r   <= cmd[1];
            own_r       <= OWN_LO;
            mem_valid_r <= 1'b1;
            pt_r        <= PT_BUSY;
          end else if (ext_req) begin
            ext_gnt_r <= 1'b1;
            pt_r      <= PT_EXT;
          end
        end
        PT_BUSY: begin
          if (mem_ready) begin
            mem_valid_r      <= 1'b0;
            done_r[own_r[0]] <= 1'b1;
            rdata_r          <= mem_rdata;
            pt_r             <= PT_IDLE;
          end
        end
        PT_EXT: begin
          if (!ext_req) begin
            ext_gnt_r <= 1'b0;
            pt_r      <= PT_IDLE;
          end
        end
        default: pt_r <= PT_IDLE;
      endcase
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign mem_cmd   = mem_cmd_r;
  assign mem_valid = mem_valid_r;
  assign ext_gnt   = ext_gnt_r;
  assign irq       = irq_r;
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_apb_wait;
    !pready ##1 pready;
  endsequence

  a_apb_one_wait: assert property ($rose(psel && penable) |-> s_apb_wait)
    else $error("APB answer not after one wait");
  a_level_follow: assert property (lvl_r == (($past(sync2_r) & ~SW_POS & EVT_VALID) | sw_events($past(trig_r))))
    else $error("Level register does not follow inputs");
  a_edge_capture: assert property (|(cap & EVT_VALID) |=> (flag_r & $past(cap & EVT_VALID)) == $past(cap & EVT_VALID))
    else $error("Captured edge not flagged");
  a_take_clears: assert property (take[0] && !cap[pick[0]] |=> !flag_r[$past(pick[0])])
    else $error("Accepted event flag not cleared");
  a_group_split: assert property ((take[0] |-> grp_r[pick[0]]) and (take[1] |-> !grp_r[pick[1]]))
    else $error("Mover served foreign group");
  a_hi_first: assert property (pt_r == PT_IDLE && want[0] |=> own_r == OWN_HI && mem_valid)
    else $error("High mover not granted first");
  a_lo_before_ext: assert property (pt_r == PT_IDLE && !want[0] && want[1] |=> own_r == OWN_LO && !ext_gnt)
    else $error("Low mover not ahead of others");
  a_no_overlap: assert property ($rose(mem_valid) && own_r == OWN_LO |-> !$past(conf[1]))
    else $error("Low mover overlapped shared region");
  a_irq_raise: assert property (take[0] && ee_now[0][EE_KIND] |=> ist_r[$past(ee_now[0][EE_IRQ +: 5])])
    else $error("Interrupt event did not set status");
  a_irq_level: assert property (|(ist_r & ien_r) |=> irq)
    else $error("Interrupt output not raised");
endmodule

// >>> verif/mem_partner.sv
// Crossbar slave model: answers alternately at once and after wait states
`timescale 1ns/100ps
module mem_partner
  import data_mover_pkg::*;
(
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Slave port
  input  data_mover_pkg::mem_cmd_s mem_cmd,
  input  wire logic                mem_valid,
  output logic                     mem_ready,
  output logic      [31:0]         mem_rdata
);
  import data_mover_pkg::*;
  logic [1:0]  wait_r;
  logic        slow_r;
  int          nwr;
  logic [31:0] wr_addr [4];
  logic [31:0] wr_data [4];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ready <= 1'b0;
      mem_rdata <= 32'hFFFF_FFFF;
      wait_r    <= 2'h0;
      slow_r    <= 1'b0;
      nwr       <= 0;
    end else begin
      mem_ready <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_valid && !mem_ready) begin
        if (wait_r == (slow_r ? 2'h3 : 2'h0)) begin
          mem_ready <= 1'b1;
          wait_r    <= 2'h0;
          slow_r    <= ~slow_r;
          if (mem_cmd.we) begin
            wr_addr[nwr[1:0]] <= mem_cmd.addr;
            wr_data[nwr[1:0]] <= mem_cmd.wdata;
            nwr               <= nwr + 1;
          end else begin
            mem_rdata <= mem_cmd.addr ^ 32'h5A5A_0000;
          end
        end else begin
          wait_r <= wait_r + 2'h1;
        end
      end
    end
  end
endmodule

// >>> verif/tb_dual_priority_data_mover.sv
// Self-checking testbench for the dual priority data mover
`timescale 1ns/100ps
module tb_dual_priority_data_mover;
  import data_mover_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] evt_pins;
  mem_cmd_s    mem_cmd;
  logic        mem_valid;
  logic        mem_ready;
  logic [31:0] mem_rdata;
  logic        ext_req;
  logic        ext_gnt;
  logic        irq;
  int          fails;
  int          checks;

  dual_priority_data_mover uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt_pins(evt_pins), .mem_cmd(mem_cmd), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata), .ext_req(ext_req), .ext_gnt(ext_gnt), .irq(irq));
  mem_partner part (.pclk(pclk), .presetn(presetn), .mem_cmd(mem_cmd), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic end_of_test;
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic timeout(input string nm);
    fails++;
    $display("Error %s expected done seen timeout", nm);
    end_of_test();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timeout("pready");
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] e);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    cmp(nm, e, rd);
    cmp({nm, "_err"}, 32'h0, {31'h0, er});
  endtask

  // Register access, unmapped and write-only places
  task automatic s_regs;
    logic [31:0] rd;
    logic        er;
    apb(1'b0, 16'h0040, 32'h0, rd, er);
    cmp("unmapped_err", 32'h1, {31'h0, er});
    cmp("unmapped_data", 32'h0, rd);
    rchk("polarity_reset", 16'(OFF_POL), 32'h0);
    wr(16'(OFF_POL), 32'h0000_00A5);
    rchk("polarity_rw", 16'(OFF_POL), 32'h0000_00A5);
    wr(16'(OFF_POL), 32'h0);
    rchk("irq_clear_wo", 16'(OFF_ICLR), 32'h0);
  endtask

  // Interrupt-type event in the high group
  task automatic s_irq;
    int n;
    wr(16'h1008, 32'h0000_0031);
    wr(16'(OFF_HIP), 32'h0000_0004);
    wr(16'(OFF_IEN), 32'h0000_0008);
    wr(16'(OFF_EN), 32'h0000_0004);
    evt_pins[2] <= 1'b1;
    n = 0;
    while (irq !== 1'b1 && n < 30) begin
      @(posedge pclk);
      n++;
    end
    if (irq !== 1'b1) timeout("irq");
    rchk("irq_status", 16'(OFF_IST), 32'h0000_0008);
    rchk("flags_taken", 16'(OFF_FLAG), 32'h0);
    wr(16'(OFF_IEN), 32'h0);
    cyc(2);
    cmp("irq_masked", 32'h0, {31'h0, irq});
    wr(16'(OFF_IEN), 32'h0000_0008);
    wr(16'(OFF_ICLR), 32'h0000_0008);
    cyc(2);
    cmp("irq_cleared", 32'h0, {31'h0, irq});
    rchk("status_cleared", 16'(OFF_IST), 32'h0);
    evt_pins[2] <= 1'b0;
    cyc(6);
  endtask

  // Falling polarity capture on a disabled event
  task automatic s_pol;
    wr(16'(OFF_POL), 32'h0000_0008);
    evt_pins[3] <= 1'b1;
    cyc(6);
    rchk("level_high", 16'(OFF_LVL), 32'h0000_0008);
    rchk("flag_no_rise", 16'(OFF_FLAG), 32'h0);
    evt_pins[3] <= 1'b0;
    cyc(6);
    rchk("level_low", 16'(OFF_LVL), 32'h0);
    rchk("flag_fall", 16'(OFF_FLAG), 32'h0000_0008);
    wr(16'(OFF_FLAG), 32'h0000_0008);
    rchk("flag_w1c", 16'(OFF_FLAG), 32'h0);
    wr(16'(OFF_POL), 32'h0);
  endtask

  // Software-started 2D circular transfer in the low group through entry seven, end interrupt 5
  task automatic s_xfer;
    int n;
    wr(16'h2000, 32'h0000_025E);
    wr(16'h21E0, 32'h0000_0100);
    wr(16'h21E4, 32'h1000_0200);
    wr(16'h21E8, 32'h0000_0201);
    wr(16'h21EC, 32'h0000_0010);
    wr(16'h21F0, 32'h0000_000C);
    wr(16'(OFF_LOP), 32'h0000_0001);
    rchk("group_mask", 16'(OFF_HIP), 32'h0000_0004);
    wr(16'(OFF_EN), 32'h0000_0001);
    wr(16'(OFF_TRIG), 32'h0001_0001);
    n = 0;
    while (part.nwr < 2 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (part.nwr < 2) timeout("transfer");
    cyc(20);
    cmp("write_count", 32'h2, 32'(part.nwr));
    cmp("dst0", 32'h1000_0200, part.wr_addr[0]);
    cmp("data0", 32'h5A5A_0100, part.wr_data[0]);
    cmp("dst1", 32'h1000_0204, part.wr_addr[1]);
    cmp("data1", 32'h5A5A_0104, part.wr_data[1]);
    rchk("level_sw", 16'(OFF_LVL), 32'h0000_0003);
    rchk("flags_sw", 16'(OFF_FLAG), 32'h0000_0002);
    rchk("xfer_done_irq", 16'(OFF_IST), 32'h0000_0020);
    wr(16'(OFF_ICLR), 32'h0000_0020);
    wr(16'(OFF_FLAG), 32'h0000_0002);
    wr(16'(OFF_TRIG), 32'h0);
  endtask

  // Another master gets the idle port and keeps it while asking
  task automatic s_ext;
    int n;
    ext_req <= 1'b1;
    n = 0;
    while (ext_gnt !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (ext_gnt !== 1'b1) timeout("ext_gnt");
    cyc(3);
    cmp("ext_held", 32'h1, {31'h0, ext_gnt});
    ext_req <= 1'b0;
    cyc(3);
    cmp("ext_released", 32'h0, {31'h0, ext_gnt});
  endtask

  initial begin
    fails    = 0;
    checks   = 0;
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 16'h0;
    pwdata   = 32'h0;
    evt_pins = 32'h0;
    ext_req  = 1'b0;
    cyc(6);
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs();
    s_irq();
    s_pol();
    s_xfer();
    s_ext();
    end_of_test();
  end
endmodule
